// File: adc_port.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - a started conversion runs to its end; strobe and power-down ignored
// - low-power mode: strobe held low while idle restarts conversion
// - only low-power mode retriggers; fast and normal modes never do
// - chip select OR read high puts the parallel and serial data outputs in high impedance
// - coding select picks straight binary or twos complement result
// - port select low: result on parallel bus, readable any time
// - lane exchange low: low byte on D[7:0]; high swaps the lanes
// - port select high: 16 result bits leave serially, MSB first
// - each master serial bit holds across both serial clock edges
// - clock source low: device makes serial clock and sync, invertible
// - master mode: read mode picks after-conversion or during-next read
// - master read-after-conversion: busy falls after all 16 bits shifted
// - clock source high: external clock shifts while select and read low
// - slave after-conversion read waits busy fall; up to 40 MHz clock
// - slave mode: read-mode pin doubles as daisy chain input
// - chain input taken on the edge opposite the shifting edge
// - slave read during conversion unfinished at its end pulses overrun
module adc_port #(
  parameter int RESULT_W = adc_port_pkg::RESULT_W
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // conversion control and configuration pins
  input  wire logic                convert_start_n,
  input  wire logic                power_down_input,
  input  wire adc_port_pkg::cfg_s  cfg_pins,
  // straight binary result from the converter core
  input  wire logic [RESULT_W-1:0] core_result,
  // host strobes
  input  wire logic                cs_n,
  input  wire logic                rd_n,
  // serial link from the host
  input  wire logic                ext_sclk,
  input  wire logic                readmode_or_chain_in,
  // status
  output logic                     busy,
  output logic                     read_overrun_flag,
  // parallel port
  output logic [RESULT_W-1:0]      data_out,
  output logic                     data_oe_n,
  // serial port
  output logic                     serial_result_out,
  output logic                     serial_result_ext,
  output logic                     serial_oe_n,
  output logic                     int_sclk_out,
  output logic                     sync_out
);
  import adc_port_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (RESULT_W != 2 * BYTE_W) begin : g_chk_w
    $error("adc_port serves a two-byte result only");
  end
  if (CONV_LOWPWR_CYC >= 2 ** CNT_W || ACQ_CYC >= 2 ** CNT_W) begin : g_chk_c
    $error("conversion counter too narrow");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int            NS       = CFG_W + 6;
  localparam logic [NS-1:0] SYNC_RST = {{CFG_W{1'h0}}, STROBE_RST};

  logic [NS-1:0]  pins_s;
  cfg_s           cfg;
  logic           cnv_s;
  logic           pd_s;
  logic           cs_s;
  logic           rd_s;
  logic           rdc_s;
  logic           tog_s;
  // link clock may stand still through reset, so these power up defined
  logic           ltog_reg = 1'h0;
  logic [BITS_W-1:0]   lcnt_reg = '0;
  logic [RESULT_W-2:0] lsh_reg  = '0;
  logic           chain_reg = 1'h0;

  sync2 #(
    .W       (NS),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({cfg_pins, convert_start_n, power_down_input, cs_n, rd_n,
             readmode_or_chain_in, ltog_reg}),
    .q     (pins_s)
  );
  assign {cfg, cnv_s, pd_s, cs_s, rd_s, rdc_s, tog_s} = pins_s;

  // ----------------------------------------------------------------
  // strobe edges and arming
  // ----------------------------------------------------------------
  logic cnv_d_reg;
  logic tog_d_reg;
  logic armed_reg;
  logic cnv_fall;
  logic link_done;
  logic master;
  logic slave;
  logic auto_go;

  assign cnv_fall  = cnv_d_reg & ~cnv_s;
  assign link_done = tog_d_reg ^ tog_s;
  assign master    = cfg.port_select & ~cfg.clock_source_select;
  assign slave     = cfg.port_select & cfg.clock_source_select;
  // fast mode wins over low power, so a fast setting never retriggers
  assign auto_go   = cfg.low_power_mode & ~cfg.fast_mode &
                     armed_reg & ~cnv_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnv_d_reg <= 1'h1;
      tog_d_reg <= 1'h0;
      armed_reg <= 1'h0;
    end else begin
      cnv_d_reg <= cnv_s;
      tog_d_reg <= tog_s;
      // retrigger stays off until the first falling strobe after reset
      if (cnv_fall) armed_reg <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  conv_state_e         st_reg;
  conv_state_e         st_next;
  logic [CNT_W-1:0]    cnt_reg;
  logic [CNT_W-1:0]    conv_len;
  logic                start_go;
  logic                conv_end;
  logic                mdone;
  logic [RESULT_W-1:0] result_reg;
  logic [RESULT_W-1:0] coded;

  assign conv_end = (st_reg == ST_CONV) && (cnt_reg == '0);
  assign conv_len = cfg.fast_mode ? CNT_W'(CONV_WARP_CYC - 1) :
                    cfg.low_power_mode ? CNT_W'(CONV_LOWPWR_CYC - 1) :
                    CNT_W'(CONV_NORMAL_CYC - 1);
  assign coded    = cfg.output_code_select ? core_result :
                    {~core_result[RESULT_W-1], core_result[RESULT_W-2:0]};

  always_comb begin
    st_next  = st_reg;
    start_go = 1'h0;
    case (st_reg)
      ST_IDLE: begin
        if (!pd_s && (cnv_fall || auto_go)) begin
          st_next  = ST_CONV;
          start_go = 1'h1;
        end
      end
      ST_ACQ: begin
        // a manual start may cut acquisition short; retrigger waits for it
        if (!pd_s && cnv_fall) begin
          st_next  = ST_CONV;
          start_go = 1'h1;
        end else if (cnt_reg == '0) begin
          st_next = ST_IDLE;
        end
      end
      ST_CONV: begin
        // strobes and power-down are not looked at here
        if (cnt_reg == '0) begin
          st_next = (master && !rdc_s) ? ST_XFER : ST_ACQ;
        end
      end
      ST_XFER: begin
        if (mdone) st_next = ST_ACQ;
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg  <= ST_IDLE;
      cnt_reg <= '0;
      busy    <= 1'h0;
    end else begin
      st_reg <= st_next;
      busy   <= (st_next == ST_CONV) ||
                (st_next == ST_XFER);
      if (start_go) begin
        cnt_reg <= conv_len;
      end else if (st_next == ST_ACQ && st_reg != ST_ACQ) begin
        cnt_reg <= CNT_W'(ACQ_CYC - 1);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_reg <= '0;
    end else if (conv_end) begin
      result_reg <= coded;
    end
  end

  // ----------------------------------------------------------------
  // parallel port and output enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out    <= '0;
      data_oe_n   <= 1'h1;
      serial_oe_n <= 1'h1;
    end else begin
      data_out    <= cfg.byte_lane_exchange ?
                     {result_reg[BYTE_W-1:0], result_reg[RESULT_W-1:BYTE_W]} :
                     result_reg;
      data_oe_n   <= cs_s | rd_s | cfg.port_select;
      serial_oe_n <= cs_s | rd_s | ~cfg.port_select;
    end
  end

  // ----------------------------------------------------------------
  // master serial shifter (four clk cycles per serial bit)
  // ----------------------------------------------------------------
  logic                mact_reg;
  logic [1:0]          qc_reg;
  logic [BITS_W-1:0]   mbits_reg;
  logic [RESULT_W-1:0] msh_reg;
  logic                mstart;
  logic [RESULT_W-1:0] mword;

  // during-conversion read sends the previous word at conversion start
  assign mstart = master && ((start_go && rdc_s) ||
                             (conv_end && !rdc_s));
  assign mword  = conv_end ? coded : result_reg;
  assign mdone  = mact_reg && (qc_reg == 2'h3) && (mbits_reg == BITS_W'(1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mact_reg          <= 1'h0;
      qc_reg            <= 2'h0;
      mbits_reg         <= '0;
      msh_reg           <= '0;
      serial_result_out <= 1'h0;
      int_sclk_out      <= 1'h0;
      sync_out          <= 1'h0;
    end else if (mstart && !mact_reg) begin
      mact_reg          <= 1'h1;
      qc_reg            <= 2'h0;
      mbits_reg         <= BITS_W'(RESULT_W);
      msh_reg           <= mword;
      serial_result_out <= mword[RESULT_W-1];
      int_sclk_out      <= cfg.sclk_invert;
      sync_out          <= ~cfg.sync_invert;
    end else if (mact_reg) begin
      qc_reg <= qc_reg + 2'h1;
      case (qc_reg)
        2'h0: int_sclk_out <= ~cfg.sclk_invert;
        2'h2: int_sclk_out <= cfg.sclk_invert;
        2'h3: begin
          // data moves one cycle after the falling edge: valid on both
          if (mbits_reg == BITS_W'(1)) begin
            mact_reg <= 1'h0;
            sync_out <= cfg.sync_invert;
          end else begin
            mbits_reg         <= mbits_reg - BITS_W'(1);
            msh_reg           <= {msh_reg[RESULT_W-2:0], 1'h0};
            serial_result_out <= msh_reg[RESULT_W-2];
          end
        end
        default: ;
      endcase
    end else begin
      int_sclk_out <= cfg.sclk_invert;
      sync_out     <= cfg.sync_invert;
    end
  end

  // ----------------------------------------------------------------
  // slave serial shifter on the host clock
  // ----------------------------------------------------------------
  // select and read frame the link in step with its clock, so they are
  // taken as link-domain levels; result_reg is only read while it holds
  logic lgate;
  assign lgate = ~cs_n & ~rd_n;

  always_ff @(posedge ext_sclk) begin
    chain_reg <= readmode_or_chain_in;
  end

  always_ff @(negedge ext_sclk) begin
    if (!lgate) begin
      lcnt_reg <= '0;
    end else if (lcnt_reg == '0) begin
      serial_result_ext <= result_reg[RESULT_W-1];
      lsh_reg           <= result_reg[RESULT_W-2:0];
      lcnt_reg          <= BITS_W'(1);
    end else begin
      // past the last bit the chain bits follow, one clock after the LSB
      serial_result_ext <= lsh_reg[RESULT_W-2];
      lsh_reg           <= {lsh_reg[RESULT_W-3:0], chain_reg};
      if (lcnt_reg != BITS_W'(RESULT_W)) lcnt_reg <= lcnt_reg + BITS_W'(1);
      if (lcnt_reg == BITS_W'(RESULT_W - 1)) ltog_reg <= ~ltog_reg;
    end
  end

  // ----------------------------------------------------------------
  // read overrun in slave read during conversion
  // ----------------------------------------------------------------
  logic rd_begun_reg;
  logic rd_done_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_begun_reg      <= 1'h0;
      rd_done_reg       <= 1'h0;
      read_overrun_flag <= 1'h0;
    end else begin
      read_overrun_flag <= conv_end && slave && rd_begun_reg &&
                           !rd_done_reg && !link_done;
      if (start_go) begin
        rd_begun_reg <= 1'h0;
        rd_done_reg  <= 1'h0;
      end
      // sets after the clears so a coinciding event is kept
      if (st_reg == ST_CONV && !cs_s && !rd_s) rd_begun_reg <= 1'h1;
      if (link_done) rd_done_reg <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [BITS_W-1:0] rise_cnt_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rise_cnt_reg <= '0;
    end else if (mstart && !mact_reg) begin
      rise_cnt_reg <= '0;
    end else if (mact_reg && qc_reg == 2'h0) begin
      rise_cnt_reg <= rise_cnt_reg + BITS_W'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_no_abort;
    st_reg == ST_CONV && cnt_reg != '0 |=> st_reg == ST_CONV;
  endproperty
  a_no_abort: assert property (p_no_abort)
    else $error("conversion left before its count ran out");

  property p_auto_go;
    st_reg == ST_IDLE && auto_go && !pd_s |=> st_reg == ST_CONV && busy;
  endproperty
  a_auto_go: assert property (p_auto_go)
    else $error("low-power retrigger did not start a conversion");

  property p_no_auto;
    st_reg == ST_IDLE && (!cfg.low_power_mode || cfg.fast_mode) &&
      !cnv_fall |=> st_reg == ST_IDLE;
  endproperty
  a_no_auto: assert property (p_no_auto)
    else $error("conversion started without a strobe edge");

  property p_hiz;
    cs_s || rd_s |=> data_oe_n && serial_oe_n;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("outputs enabled while deselected");

  property p_coding;
    conv_end |=> result_reg[RESULT_W-1] ==
      ($past(cfg.output_code_select) ~^ $past(core_result[RESULT_W-1]));
  endproperty
  a_coding: assert property (p_coding)
    else $error("result coding wrong");

  property p_lanes;
    cfg.byte_lane_exchange
      |=> data_out[RESULT_W-1:BYTE_W] == $past(result_reg[BYTE_W-1:0]);
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("byte lanes not exchanged");

  property p_sixteen;
    mdone |-> rise_cnt_reg == BITS_W'(RESULT_W);
  endproperty
  a_sixteen: assert property (p_sixteen)
    else $error("master transfer pulse count wrong");

  property p_bit_hold;
    mact_reg && qc_reg == 2'h0 |=> $stable(serial_result_out) [*3];
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("serial bit moved around a clock edge");

  property p_sync;
    mact_reg |-> sync_out != cfg.sync_invert;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync inactive during master transfer");

  property p_busy_xfer;
    st_reg == ST_XFER |=> busy == !$past(mdone);
  endproperty
  a_busy_xfer: assert property (p_busy_xfer)
    else $error("busy not held to the end of the master transfer");

  property p_overrun;
    read_overrun_flag |-> $past(conv_end) ##1 !read_overrun_flag;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun pulse out of place");

  property p_busy_start;
    start_go |=> busy [*8];
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy not raised for a conversion");

  c_auto: cover property (st_reg == ST_IDLE && auto_go ##1 st_reg == ST_CONV);
  c_master: cover property (mdone && st_reg == ST_XFER);
  c_overrun: cover property (read_overrun_flag);
  c_slave: cover property (link_done);

endmodule : adc_port
`default_nettype wire

// File: adc_port_pkg.sv
`default_nettype none
package adc_port_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RESULT_W = 16;
  localparam int BYTE_W   = 8;
  localparam int CNT_W    = 8;
  localparam int BITS_W   = 5;

  // ----------------------------------------------------------------
  // timing (clock rate, times in ns, derived cycle counts)
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int T_CONV_WARP_NS   = 700;
  localparam int T_CONV_NORMAL_NS = 900;
  localparam int T_CONV_LOWPWR_NS = 1100;
  localparam int T_ACQ_NS         = 400;
  // least times: round up to whole cycles
  localparam int CONV_WARP_CYC   = (T_CONV_WARP_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_NORMAL_CYC = (T_CONV_NORMAL_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_LOWPWR_CYC = (T_CONV_LOWPWR_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ_CYC         = (T_ACQ_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // configuration pins
  // ----------------------------------------------------------------
  typedef struct packed {
    logic port_select;
    logic clock_source_select;
    logic byte_lane_exchange;
    logic output_code_select;
    logic low_power_mode;
    logic fast_mode;
    logic sclk_invert;
    logic sync_invert;
  } cfg_s;
  localparam int CFG_W = $bits(cfg_s);

  // reset image of {convert_start_n, power_down, cs_n, rd_n, readmode, tog}
  localparam logic [5:0] STROBE_RST = 6'h2C;

  // ----------------------------------------------------------------
  // conversion sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONV = 4'h2,
    ST_XFER = 4'h4,
    ST_ACQ  = 4'h8
  } conv_state_e;

endpackage : adc_port_pkg
`default_nettype wire

// File: sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : sync2
`default_nettype wire

// File: host_serial.sv
`timescale 1ns/1ps
`default_nettype none
module host_serial (
  // serial link
  output logic      ext_sclk,
  input  wire logic sdo
);
  // ----------
  // clock owner
  // ----------
  // discontinuous clock, idles low between frames
  initial ext_sclk = 1'b0;

  // 15 ns period; bench calls it only while busy is low
  task automatic read(input int n, output logic [31:0] w);
    int i;
    w = '0;
    #3.3;
    for (i = 0; i < n; i++) begin
      ext_sclk = 1'b1;
      #7.5;
      ext_sclk = 1'b0;
      #7.5;
      // bit held until the next fall, taken at the next rise
      w = {w[30:0], sdo};
    end
    ext_sclk = 1'b1;
    #7.5;
    ext_sclk = 1'b0;
  endtask : read
endmodule : host_serial
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_port_pkg::*;
  // ----------
  // signals
  // ----------
  logic          clk;
  logic          rst_n;
  logic          convert_start_n;
  logic          power_down_input;
  cfg_s          cfg_pins;
  logic [15:0]   core_result;
  logic          cs_n;
  logic          rd_n;
  logic          ext_sclk;
  logic          readmode_or_chain_in;
  logic          busy;
  logic          read_overrun_flag;
  logic [15:0]   data_out;
  logic          data_oe_n;
  logic          serial_result_out;
  logic          serial_result_ext;
  logic          serial_oe_n;
  logic          int_sclk_out;
  logic          sync_out;
  logic [31:0]   w;
  int            mismatches;
  int            n_checks;
  int            width;

  adc_port dut (.clk, .rst_n, .convert_start_n, .power_down_input,
    .cfg_pins, .core_result, .cs_n, .rd_n, .ext_sclk,
    .readmode_or_chain_in, .busy, .read_overrun_flag, .data_out,
    .data_oe_n, .serial_result_out, .serial_result_ext, .serial_oe_n,
    .int_sclk_out, .sync_out);
  host_serial h (.ext_sclk, .sdo(serial_result_ext));

  always #5 clk = ~clk;

  // ----------
  // helpers
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // one strobe, then the busy-high cycles are counted
  task automatic conv(output int bw);
    int i;
    bw = 0;
    convert_start_n = 1'b0;
    step(3);
    convert_start_n = 1'b1;
    for (i = 0; i < 20 && busy !== 1'b1; i++) step(1);
    while (busy === 1'b1 && bw < 3000) begin
      bw++;
      step(1);
    end
  endtask : conv

  // ----------
  // scenarios
  // ----------
  task automatic t_no_abort;
    fork
      conv(width);
      begin
        step(30);
        power_down_input = 1'b1;
        convert_start_n = 1'b0;
        step(3);
        convert_start_n = 1'b1;
        power_down_input = 1'b0;
      end
    join
    check(width, CONV_WARP_CYC);
    step(ACQ_CYC + 5);
  endtask : t_no_abort

  // read after conversion keeps clear of the conversion
  task automatic t_parallel;
    int i;
    logic [15:0] e;
    for (i = 0; i < 4; i++) begin
      cfg_pins.output_code_select = i[0];
      cfg_pins.byte_lane_exchange = i[1];
      core_result = 16'hA5C6 + 16'(i);
      step(4);
      conv(width);
      e = i[0] ? core_result : core_result ^ 16'h8000;
      if (i[1]) e = {e[7:0], e[15:8]};
      cs_n = 1'b0;
      rd_n = 1'b0;
      step(5);
      check(data_oe_n, 0);
      check(data_out, e);
      if (i[0]) cs_n = 1'b1;
      else rd_n = 1'b1;
      step(5);
      check(data_oe_n, 1);
      cs_n = 1'b1;
      rd_n = 1'b1;
      step(ACQ_CYC);
    end
  endtask : t_parallel

  task automatic t_retrig(input logic lp, input logic fast);
    int i;
    logic again;
    cfg_pins.low_power_mode = lp;
    cfg_pins.fast_mode = fast;
    step(4);
    convert_start_n = 1'b0; // first fall arms the restart
    for (i = 0; i < 20 && busy !== 1'b1; i++) step(1);
    for (i = 0; i < 3000 && busy === 1'b1; i++) step(1);
    again = 1'b0;
    for (i = 0; i < ACQ_CYC + 100; i++) begin
      step(1);
      if (busy === 1'b1) again = 1'b1;
    end
    convert_start_n = 1'b1;
    check(again, lp & ~fast);
    for (i = 0; i < 3000 && busy === 1'b1; i++) step(1);
    step(ACQ_CYC + 5);
  endtask : t_retrig

  task automatic t_slave;
    cfg_pins = '{port_select: 1, clock_source_select: 1,
                 output_code_select: 1, fast_mode: 1, default: 0};
    readmode_or_chain_in = 1'b1;
    core_result = 16'hA5C6;
    step(4);
    conv(width);
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(4);
    check(serial_oe_n, 0);
    h.read(17, w);
    check(w, {15'h0, 16'hA5C6, 1'b1});
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(5);
    check(serial_oe_n, 1);
  endtask : t_slave

  task automatic t_overrun;
    int i;
    logic seen;
    seen = 1'b0;
    readmode_or_chain_in = 1'b0;
    fork
      conv(width);
      begin
        step(10);
        cs_n = 1'b0;
        rd_n = 1'b0;
      end
      for (i = 0; i < 200; i++) begin
        step(1);
        if (read_overrun_flag === 1'b1) seen = 1'b1;
      end
    join
    check(seen, 1);
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(ACQ_CYC + 5);
  endtask : t_overrun

  task automatic t_master(input logic rdc, input logic [15:0] r,
                          input logic [15:0] e);
    int i;
    int n;
    logic prev;
    logic bz;
    logic sbad;
    cfg_pins = '{port_select: 1, output_code_select: 1, fast_mode: 1,
                 sclk_invert: 1, sync_invert: 1, default: 0};
    step(6);
    check({int_sclk_out, sync_out}, 2'b11);
    cfg_pins.sclk_invert = 1'b0;
    cfg_pins.sync_invert = 1'b0;
    readmode_or_chain_in = rdc;
    core_result = r;
    step(6);
    n = 0;
    w = '0;
    prev = 1'b0;
    sbad = 1'b0;
    bz = 1'b0;
    fork
      conv(width);
      for (i = 0; i < 400; i++) begin
        step(1);
        if (int_sclk_out === 1'b1 && prev === 1'b0) begin
          w = {w[30:0], serial_result_out};
          n++;
          if (sync_out !== 1'b1) sbad = 1'b1;
          if (n == 16) bz = busy;
        end
        prev = int_sclk_out;
      end
    join
    check(w, {16'h0, e});
    check(n, 16);
    check(sbad, 0);
    check(bz, 1);
    if (rdc) check(width, CONV_WARP_CYC);
    else check(width > CONV_WARP_CYC + 60, 1);
    step(ACQ_CYC + 5);
  endtask : t_master

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // ----------
  // main sequence
  // ----------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    convert_start_n = 1'b1;
    power_down_input = 1'b0;
    cfg_pins = '{fast_mode: 1, default: 0};
    core_result = '0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    readmode_or_chain_in = 1'b0;
    mismatches = 0;
    n_checks = 0;
    step(12);
    rst_n = 1'b1;
    step(2);
    check({busy, data_oe_n, serial_oe_n}, 3'b011);
    t_no_abort();
    t_parallel();
    t_retrig(1'b1, 1'b0);
    t_retrig(1'b0, 1'b1);
    t_retrig(1'b0, 1'b0);
    t_retrig(1'b1, 1'b1);
    t_slave();
    t_overrun();
    t_master(1'b0, 16'h3C5A, 16'h3C5A);
    t_master(1'b1, 16'h1234, 16'h3C5A);
    test_done();
  end

  initial begin
    #200000;
    mismatches++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
